// ---- design/adgc_config_bank.sv ----
// gain engine, biquad and input channel configuration register bank
//
// Contract
// - two-bit biquad stage count 0..3, zero disables all, resets to two
// - soft-step disable bit: 0 ramps volume, mute and unmute; 1 does not
// - selector bit picks range boost engine (0) or auto gain engine (1)
// - trigger threshold code 0..9 maps -12 dB to -66 dB; 10..15 reserved
// - range boost gain limit code 0..12 maps 2 to 26 dB; rest reserved
// - trigger threshold resets to code seven, -54 dB
// - range boost gain limit resets to code eleven, 24 dB
// - auto gain target code 0..15 maps -6 dB to -36 dB
// - auto gain target resets to code fourteen, -34 dB
// - auto gain limit code 0..13 maps 3 to 42 dB; 14, 15 reserved
// - eight channel enables, channel one at bit 7 down to eight at bit 0
// - channels one to four enabled after reset
// - microphone-only channels five to eight disabled after reset
`timescale 1ns/1ns
`include "adgc_params.svh"

module adgc_config_bank (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic [1:0] biquad_stages,
  output logic soft_step_on,
  output adgc_pkg::adgc_engine_t gain_engine_pick,
  output logic [3:0] range_boost_trigger_level,
  output logic [3:0] range_boost_gain_limit,
  output logic [3:0] auto_gain_target_level,
  output logic [3:0] auto_gain_limit,
  output logic [7:0] range_boost_trigger_neg_db,
  output logic [7:0] range_boost_gain_limit_db,
  output logic [7:0] auto_gain_target_neg_db,
  output logic [7:0] auto_gain_limit_db,
  output logic cfg_code_reserved,
  output logic input_ch1_on,
  output logic input_ch2_on,
  output logic input_ch3_on,
  output logic input_ch4_on,
  output logic input_ch5_on,
  output logic input_ch6_on,
  output logic input_ch7_on,
  output logic input_ch8_on
);

  // ***************************************************************
  // helpers
  // ***************************************************************

  // linear code to dB magnitude: base + step * code, fits in 8 bits
  function automatic logic [7:0] code_to_db(
    input logic [3:0] code,
    input logic [7:0] base,
    input logic [7:0] step
  );
    logic [11:0] prod;
    prod = 12'({8'h00, code} * {4'h0, step});
    code_to_db = 8'(prod + {4'h0, base});
  endfunction

  // true when the software write targets this offset
  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    hit = (addr == ofs);
  endfunction

  // ***************************************************************
  // storage registers
  // ***************************************************************
  adgc_pkg::adgc_byte_t proc_setup_b_ff;
  adgc_pkg::adgc_byte_t range_boost_setup_ff;
  adgc_pkg::adgc_byte_t auto_gain_setup_ff;
  adgc_pkg::adgc_byte_t input_channel_enables_ff;

  // processing setup b: gang, biquads, soft step, engine pick, low bits
  // reserved low bits stay writable so software sees what it wrote
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      proc_setup_b_ff <= `ADGC_RST_PROC_SETUP_B;
    end else if (reg_wr_en && hit(reg_addr, `ADGC_OFS_PROC_SETUP_B)) begin
      proc_setup_b_ff <= reg_wdata;
    end
  end

  // range boost thresholds, reset code 7 / code 11
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      range_boost_setup_ff <= `ADGC_RST_RANGE_BOOST;
    end else if (reg_wr_en && hit(reg_addr, `ADGC_OFS_RANGE_BOOST)) begin
      range_boost_setup_ff <= reg_wdata;
    end
  end

  // auto gain target and limit, reset code 14 / code 7
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      auto_gain_setup_ff <= `ADGC_RST_AUTO_GAIN;
    end else if (reg_wr_en && hit(reg_addr, `ADGC_OFS_AUTO_GAIN)) begin
      auto_gain_setup_ff <= reg_wdata;
    end
  end

  // channel enables: analog-capable four on, microphone-only four off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_channel_enables_ff <= `ADGC_RST_INPUT_CHANNEL_ENABLES;
    end else if (reg_wr_en && hit(reg_addr, `ADGC_OFS_INPUT_CHANNEL_ENABLES)) begin
      input_channel_enables_ff <= reg_wdata;
    end
  end

  // ***************************************************************
  // read port
  // ***************************************************************

  // read data lands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        case (reg_addr)
          `ADGC_OFS_PROC_SETUP_B: reg_rdata <= proc_setup_b_ff;
          `ADGC_OFS_RANGE_BOOST: reg_rdata <= range_boost_setup_ff;
          `ADGC_OFS_AUTO_GAIN: reg_rdata <= auto_gain_setup_ff;
          `ADGC_OFS_INPUT_CHANNEL_ENABLES: reg_rdata <= input_channel_enables_ff;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ***************************************************************
  // datapath controls
  // ***************************************************************

  // field copies for the dsp path, one cycle behind the store
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // reset copies derive from the stored reset bytes so both agree
      biquad_stages <= 2'(`ADGC_RST_PROC_SETUP_B >> `ADGC_BIQUAD_LSB);
      soft_step_on <= 1'(~(`ADGC_RST_PROC_SETUP_B >> `ADGC_NO_SOFT_STEP_BIT));
      gain_engine_pick <= adgc_pkg::adgc_engine_t'(
        1'(`ADGC_RST_PROC_SETUP_B >> `ADGC_ENGINE_PICK_BIT));
      range_boost_trigger_level <=
        4'(`ADGC_RST_RANGE_BOOST >> `ADGC_HI_NIB_LSB);
      range_boost_gain_limit <= 4'(`ADGC_RST_RANGE_BOOST);
      auto_gain_target_level <= 4'(`ADGC_RST_AUTO_GAIN >> `ADGC_HI_NIB_LSB);
      auto_gain_limit <= 4'(`ADGC_RST_AUTO_GAIN);
    end else begin
      biquad_stages <=
        proc_setup_b_ff[`ADGC_BIQUAD_MSB:`ADGC_BIQUAD_LSB];
      // active-high enable is the inverse of the stored disable bit
      soft_step_on <= ~proc_setup_b_ff[`ADGC_NO_SOFT_STEP_BIT];
      gain_engine_pick <= adgc_pkg::adgc_engine_t'(
        proc_setup_b_ff[`ADGC_ENGINE_PICK_BIT]);
      range_boost_trigger_level <=
        range_boost_setup_ff[`ADGC_HI_NIB_MSB:`ADGC_HI_NIB_LSB];
      range_boost_gain_limit <=
        range_boost_setup_ff[`ADGC_LO_NIB_MSB:`ADGC_LO_NIB_LSB];
      auto_gain_target_level <=
        auto_gain_setup_ff[`ADGC_HI_NIB_MSB:`ADGC_HI_NIB_LSB];
      auto_gain_limit <= auto_gain_setup_ff[`ADGC_LO_NIB_MSB:`ADGC_LO_NIB_LSB];
    end
  end

  // dB magnitudes; reserved codes extrapolate, flagged below instead
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      range_boost_trigger_neg_db <= `ADGC_RST_TRIG_DB;
      range_boost_gain_limit_db <= `ADGC_RST_RBGAIN_DB;
      auto_gain_target_neg_db <= `ADGC_RST_TGT_DB;
      auto_gain_limit_db <= `ADGC_RST_AGLIM_DB;
    end else begin
      range_boost_trigger_neg_db <= code_to_db(
        range_boost_setup_ff[`ADGC_HI_NIB_MSB:`ADGC_HI_NIB_LSB],
        `ADGC_TRIG_BASE_DB, `ADGC_TRIG_STEP_DB);
      range_boost_gain_limit_db <= code_to_db(
        range_boost_setup_ff[`ADGC_LO_NIB_MSB:`ADGC_LO_NIB_LSB],
        `ADGC_RBGAIN_BASE_DB, `ADGC_RBGAIN_STEP_DB);
      auto_gain_target_neg_db <= code_to_db(
        auto_gain_setup_ff[`ADGC_HI_NIB_MSB:`ADGC_HI_NIB_LSB],
        `ADGC_TGT_BASE_DB, `ADGC_TGT_STEP_DB);
      auto_gain_limit_db <= code_to_db(
        auto_gain_setup_ff[`ADGC_LO_NIB_MSB:`ADGC_LO_NIB_LSB],
        `ADGC_AGLIM_BASE_DB, `ADGC_AGLIM_STEP_DB);
    end
  end

  // reserved-code flag: hardware cannot refuse a write, only report it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_code_reserved <= 1'b0;
    end else begin
      cfg_code_reserved <=
        (range_boost_setup_ff[`ADGC_HI_NIB_MSB:`ADGC_HI_NIB_LSB] >
         `ADGC_TRIG_MAX_CODE) ||
        (range_boost_setup_ff[`ADGC_LO_NIB_MSB:`ADGC_LO_NIB_LSB] >
         `ADGC_RBGAIN_MAX_CODE) ||
        (auto_gain_setup_ff[`ADGC_LO_NIB_MSB:`ADGC_LO_NIB_LSB] >
         `ADGC_AGLIM_MAX_CODE);
    end
  end

  // per-channel enables, channel one in the top bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {input_ch1_on, input_ch2_on, input_ch3_on, input_ch4_on,
       input_ch5_on, input_ch6_on, input_ch7_on, input_ch8_on} <=
        `ADGC_RST_INPUT_CHANNEL_ENABLES;
    end else begin
      {input_ch1_on, input_ch2_on, input_ch3_on, input_ch4_on,
       input_ch5_on, input_ch6_on, input_ch7_on, input_ch8_on} <=
        input_channel_enables_ff;
    end
  end

endmodule // adgc_config_bank

// ---- common/adgc_params.svh ----
// register offsets, field positions, reset values and dB mapping constants
`ifndef ADGC_PARAMS_SVH
`define ADGC_PARAMS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define ADGC_OFS_PROC_SETUP_B 8'h6C
`define ADGC_OFS_RANGE_BOOST 8'h6D
`define ADGC_OFS_AUTO_GAIN 8'h70
`define ADGC_OFS_INPUT_CHANNEL_ENABLES 8'h73

// ***************************************************************
// reset values
// ***************************************************************
`define ADGC_RST_PROC_SETUP_B 8'h40
`define ADGC_RST_RANGE_BOOST 8'h7B
`define ADGC_RST_AUTO_GAIN 8'hE7
`define ADGC_RST_INPUT_CHANNEL_ENABLES 8'hF0
// dB magnitudes of the reset codes: 7, B, E and 7
`define ADGC_RST_TRIG_DB 8'h36
`define ADGC_RST_RBGAIN_DB 8'h18
`define ADGC_RST_TGT_DB 8'h22
`define ADGC_RST_AGLIM_DB 8'h18

// ***************************************************************
// field positions
// ***************************************************************
`define ADGC_VOL_GANG_BIT 7
`define ADGC_BIQUAD_MSB 6
`define ADGC_BIQUAD_LSB 5
`define ADGC_NO_SOFT_STEP_BIT 4
`define ADGC_ENGINE_PICK_BIT 3
`define ADGC_HI_NIB_MSB 7
`define ADGC_HI_NIB_LSB 4
`define ADGC_LO_NIB_MSB 3
`define ADGC_LO_NIB_LSB 0

// ***************************************************************
// code to dB mapping: base magnitude, step, last legal code
// ***************************************************************
`define ADGC_TRIG_BASE_DB 8'h0C
`define ADGC_TRIG_STEP_DB 8'h06
`define ADGC_TRIG_MAX_CODE 4'h9
`define ADGC_RBGAIN_BASE_DB 8'h02
`define ADGC_RBGAIN_STEP_DB 8'h02
`define ADGC_RBGAIN_MAX_CODE 4'hC
`define ADGC_TGT_BASE_DB 8'h06
`define ADGC_TGT_STEP_DB 8'h02
`define ADGC_AGLIM_BASE_DB 8'h03
`define ADGC_AGLIM_STEP_DB 8'h03
`define ADGC_AGLIM_MAX_CODE 4'hD

`endif

// ---- common/adgc_pkg.sv ----
// types shared by the gain and channel configuration bank
package adgc_pkg;

  // which gain engine acts on enabled channels
  typedef enum logic {
    ADGC_ENGINE_RANGE_BOOST,
    ADGC_ENGINE_AUTO_GAIN
  } adgc_engine_t;

  typedef logic [7:0] adgc_byte_t;

endpackage

// ---- verification/adgc_config_bank_chk.sv ----
// port assertions for the gain and channel configuration bank
`timescale 1ns/1ns
module adgc_config_bank_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic [1:0] biquad_stages,
  input wire logic soft_step_on,
  input wire logic gain_engine_pick,
  input wire logic [3:0] range_boost_trigger_level,
  input wire logic [3:0] range_boost_gain_limit,
  input wire logic [3:0] auto_gain_target_level,
  input wire logic [3:0] auto_gain_limit,
  input wire logic [7:0] range_boost_trigger_neg_db,
  input wire logic [7:0] range_boost_gain_limit_db,
  input wire logic [7:0] auto_gain_target_neg_db,
  input wire logic [7:0] auto_gain_limit_db
);
  // ***************************************************************
  // fields follow a write two samples later; dB always tracks code
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_biquad_from_write: assert property (reg_wr_en && reg_addr == 8'h6C
    |-> ##2 biquad_stages == $past(reg_wdata[6:5], 2)) else $error("biquad");
  a_soft_step_inv: assert property (reg_wr_en && reg_addr == 8'h6C
    |=> ##1 soft_step_on == !$past(reg_wdata[4], 2)) else $error("soft step");
  a_engine_from_bit: assert property (reg_wr_en && reg_addr == 8'h6C
    |-> ##2 gain_engine_pick == $past(reg_wdata[3], 2)) else $error("engine");
  a_boost_codes_write: assert property (
    reg_wr_en && reg_addr == 8'h6D
    |-> ##2 {range_boost_trigger_level, range_boost_gain_limit}
    == $past(reg_wdata, 2)) else $error("boost codes");
  a_trig_db_map: assert property (range_boost_trigger_neg_db ==
    8'h0C + 8'h06 * range_boost_trigger_level) else $error("trigger dB");
  a_boost_gain_db: assert property (range_boost_gain_limit_db ==
    8'h02 + 8'h02 * range_boost_gain_limit) else $error("boost gain dB");
  a_target_db_map: assert property (auto_gain_target_neg_db ==
    8'h06 + 8'h02 * auto_gain_target_level) else $error("target dB");
  a_limit_db_map: assert property (auto_gain_limit_db ==
    8'h03 + 8'h03 * auto_gain_limit) else $error("gain limit dB");
endmodule // adgc_config_bank_chk

bind adgc_config_bank adgc_config_bank_chk adgc_config_bank_chk_i (.core_clk,
  .rst, .reg_addr, .reg_wdata, .reg_wr_en, .biquad_stages, .soft_step_on,
  .gain_engine_pick, .range_boost_trigger_level, .range_boost_gain_limit,
  .auto_gain_target_level, .auto_gain_limit, .range_boost_trigger_neg_db,
  .range_boost_gain_limit_db, .auto_gain_target_neg_db, .auto_gain_limit_db);

// ---- verification/adgc_config_bank_tb.sv ----
// self-checking bench for the gain and channel configuration bank
`timescale 1ns/1ns
module adgc_config_bank_tb;
  // ***************************************************************
  // signals, shadow registers and expectation queue
  // ***************************************************************
  logic core_clk, rst, reg_wr_en, reg_rd_en, reg_rd_valid, soft_step_on;
  logic cfg_code_reserved, input_ch1_on, input_ch2_on, input_ch3_on;
  logic input_ch4_on, input_ch5_on, input_ch6_on, input_ch7_on, input_ch8_on;
  logic [1:0] biquad_stages;
  logic [3:0] range_boost_trigger_level, range_boost_gain_limit;
  logic [3:0] auto_gain_target_level, auto_gain_limit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, range_boost_trigger_neg_db;
  logic [7:0] range_boost_gain_limit_db, auto_gain_target_neg_db;
  logic [7:0] auto_gain_limit_db, a, d;
  adgc_pkg::adgc_engine_t gain_engine_pick;
  logic [7:0] ofs [4] = '{8'h6C, 8'h6D, 8'h70, 8'h73};
  logic [7:0] rstv [4] = '{8'h40, 8'h7B, 8'hE7, 8'hF0};
  logic [7:0] sh [4];
  logic [7:0] expq [$];
  int miscompares = 0, tests_run = 0, cycles = 0, k;
  integer seed = 32'h1FF3151D;

  adgc_config_bank adgc_config_bank_i (.core_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr_en, .reg_rd_en, .reg_rdata, .reg_rd_valid, .biquad_stages,
    .soft_step_on, .gain_engine_pick, .range_boost_trigger_level,
    .range_boost_gain_limit, .auto_gain_target_level, .auto_gain_limit,
    .range_boost_trigger_neg_db, .range_boost_gain_limit_db,
    .auto_gain_target_neg_db, .auto_gain_limit_db, .cfg_code_reserved,
    .input_ch1_on, .input_ch2_on, .input_ch3_on, .input_ch4_on,
    .input_ch5_on, .input_ch6_on, .input_ch7_on, .input_ch8_on);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // unmapped writes leave the shadow alone, just as the bank ignores them
  task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
    @(negedge core_clk);
    {reg_wr_en, reg_addr, reg_wdata} = {1'b1, wa, wd};
    foreach (ofs[i]) if (ofs[i] == wa) sh[i] = wd;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ra);
    @(negedge core_clk);
    {reg_rd_en, reg_addr} = {1'b1, ra};
    expq.push_back(8'h00);
    foreach (ofs[i]) if (ofs[i] == ra) expq[$] = sh[i];
    @(negedge core_clk);
    reg_rd_en = 1'b0;
  endtask
  // fields land one edge after the register, so wait one more edge
  task automatic chk_fields;
    @(negedge core_clk);
    check({6'h00, biquad_stages}, {6'h00, sh[0][6:5]});
    check({7'h00, soft_step_on}, {7'h00, ~sh[0][4]});
    check({7'h00, gain_engine_pick}, {7'h00, sh[0][3]});
    check({range_boost_trigger_level, range_boost_gain_limit}, sh[1]);
    check({auto_gain_target_level, auto_gain_limit}, sh[2]);
    check(range_boost_trigger_neg_db, 8'h0C + 8'h06 * sh[1][7:4]);
    check(range_boost_gain_limit_db, 8'h02 + 8'h02 * sh[1][3:0]);
    check(auto_gain_target_neg_db, 8'h06 + 8'h02 * sh[2][7:4]);
    check(auto_gain_limit_db, 8'h03 + 8'h03 * sh[2][3:0]);
    check({input_ch1_on, input_ch2_on, input_ch3_on, input_ch4_on,
      input_ch5_on, input_ch6_on, input_ch7_on, input_ch8_on}, sh[3]);
    check({7'h00, cfg_code_reserved}, {7'h00,
      sh[1][7:4] > 4'h9 || sh[1][3:0] > 4'hC || sh[2][3:0] > 4'hD});
  endtask
  task automatic reset_reads;
    sh = rstv;
    foreach (ofs[i]) rd(ofs[i]);
    chk_fields;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // read data judged against the oldest note; a stray answer fails
  always @(posedge core_clk) begin
    #1;
    if (reg_rd_valid === 1'b1)
      check(reg_rdata, expq.size() > 0 ? expq.pop_front() : 8'hXX);
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    {rst, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {3'h4, 16'h0000};
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    reset_reads;
    $display("reset values done");
    // every code of every field but gang and channel enables, reserved low bits kept at zero; each
    // reserved term rises alone: gain c<3, limit c=8,9, trigger c>9
    for (int c = 0; c < 16; c++) begin
      wr(8'h6C, {1'b0, 4'(c), 3'h0});
      wr(8'h6D, {4'(c), 4'(15 - c)});
      wr(8'h70, {4'(c), 4'(c + 6)});
      chk_fields;
      check({7'h00, cfg_code_reserved},
        {7'h00, c < 3 || c > 7});
    end
    $display("code sweep done");
    for (int n = 0; n < 24; n++) begin
      k = $unsigned($random(seed)) % 5;
      d = 8'($random(seed));
      a = k < 4 ? ofs[k] : 8'h6E;
      wr(a, d);
      rd(a);
      chk_fields;
    end
    $display("random access done");
    // write and read together: the read returns the old contents
    @(negedge core_clk);
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {2'h3, 16'h730F};
    expq.push_back(sh[3]);
    sh[3] = 8'h0F;
    @(negedge core_clk);
    {reg_wr_en, reg_rd_en} = 2'h0;
    rd(8'h73);
    chk_fields;
    $display("overlap done");
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    reset_reads;
    $display("second reset done");
    final_report;
  end
endmodule // adgc_config_bank_tb
